// >>> flash_nvm_defs.svh
/*
 * Constants of the embedded flash storage block: geometry, address
 * widths, read latencies and status codes.
 * Assumes it is included by bare name after the guard below.
 */
`ifndef FLASH_NVM_DEFS_SVH
`define FLASH_NVM_DEFS_SVH

// ****************************************************************
// Geometry
// ****************************************************************
`define NVM_SECTORS       64
`define NVM_PAGES         33
`define NVM_BLOCKS        9
`define NVM_DATA_BLOCKS   8
`define NVM_BLOCK_BITS    128
`define NVM_CHECK_BITS    8
`define NVM_ECC_BITS      9
`define NVM_USER_BITS     2097152
`define NVM_WORDS         19008
`define NVM_ADDR_BITS     15
`define NVM_SPARE_PAGE    6'h20
`define NVM_AUX_BLOCK     4'h8
`define NVM_LAST_BLOCK    4'h8
`define NVM_LAST_DATA_BLK 3'h7
`define NVM_LAST_USR_PAGE 5'h1F

// ****************************************************************
// Read latencies in core_clk cycles
// ****************************************************************
`define NVM_RD_LAT_FIVE   4'h5
`define NVM_RD_LAT_SIX    4'h6

// ****************************************************************
// Status codes
// ****************************************************************
`define NVM_ST_OK         2'h0
`define NVM_ST_CORRECTED  2'h1
`define NVM_ST_DOUBLE     2'h2
`define NVM_ST_REFUSED    2'h3

`endif

// >>> flash_nvm_pkg.sv
/*
 * Types shared by the flash storage block: controller states and the
 * packed state record of the controller.
 * Assumes flash_nvm_defs.svh is on the include path.
 */
`include "flash_nvm_defs.svh"

package flash_nvm_pkg;

    typedef enum logic [1:0] {
        st_idle,
        st_read,
        st_program,
        st_erase
    } op_state_e;

    typedef logic [`NVM_BLOCK_BITS-1:0] block_t;

    typedef struct packed {
        op_state_e                     st;
        logic [3:0]                    cnt;
        logic                          lat6;
        logic [5:0]                    sec;
        logic [5:0]                    page;
        logic [3:0]                    blk;
        logic [`NVM_BLOCKS-1:0][127:0] pbuf;
        logic [`NVM_BLOCKS-1:0]        pvalid;
        logic [5:0]                    psec;
        logic [5:0]                    ppage;
        logic [`NVM_SECTORS-1:0]       protect;
        logic                          set_prot;
        logic                          clr_prot;
        logic [127:0]                  rdata;
        logic [1:0]                    status;
        logic                          rvalid;
        logic                          done;
    } state_s;

endpackage

// >>> flash_nvm_array.sv
/*
 * Single-port storage array of the flash block: one word per block,
 * data with its check bits, read data registered.
 * Assumes one clock; contents are undefined until first written.
 */
`timescale 1ns/100ps
`default_nettype none

module flash_nvm_array #(
    parameter int WIDTH  = 137,
    parameter int DEPTH  = 19008,
    parameter int ABITS  = 15
) (
    // Clock
    input  wire logic             core_clk,
    // Access
    input  wire logic             we,
    input  wire logic [ABITS-1:0] addr,
    input  wire logic [WIDTH-1:0] wdata,
    output logic      [WIDTH-1:0] rdata
);

    logic [WIDTH-1:0] mem [DEPTH];

    // The array has no reset: a flash cell keeps its value regardless.
    always_ff @(posedge core_clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end

endmodule

`default_nettype wire

// >>> flash_nvm_ctrl.sv
/*
 * Flash storage block controller: page buffer, block buffer, SECDED
 * check bits per block, page program and erase, and reads in five or
 * six cycle mode.
 * Assumes user logic on core_clk drives all request inputs, one
 * request at a time while busy is low.
 */
// How it works
// - Controls and data are active high; clock rises, reset is low.
// - All operations happen on the rising edge of core_clk.
// - User storage is 2 Mbit: 64 sectors, 32 pages, 8 blocks.
// - Array is 64 sectors of 33 pages; programmed data lives there, and buffered writes stay in the page buffer until programmed.
// - A volatile page buffer holds 8 data blocks plus an aux block.
// - The block buffer keeps the last block read, 128 bits.
// - Each block stores check bits; single errors fixed, doubles seen.
// - Reads take five or six cycles; data, busy, status on edges.
`timescale 1ns/100ps
`default_nettype none

module flash_nvm_ctrl
    import flash_nvm_pkg::*;
(
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         arst_n,
    // Address
    input  wire logic [5:0]   addr_sector,
    input  wire logic [4:0]   addr_page,
    input  wire logic [2:0]   addr_block,
    input  wire logic         aux_block_select,
    input  wire logic         reserved_page_select,
    // Requests
    input  wire logic         read_en,
    input  wire logic         sequential_read_request,
    input  wire logic         six_cycle_read,
    input  wire logic         write_en,
    input  wire logic [127:0] write_data,
    input  wire logic         program_en,
    input  wire logic         erase_page,
    input  wire logic         page_buffer_drop,
    input  wire logic         page_write_unlock,
    input  wire logic         protection_rewrite,
    // Answers
    output logic              busy,
    output logic [127:0]      read_data,
    output logic [1:0]        status,
    output logic              read_valid,
    output logic              op_done
);

    localparam int WORD = `NVM_BLOCK_BITS + `NVM_ECC_BITS;

    // ************************************************************
    // Check bit code
    // ************************************************************
    function automatic logic [136:1] spread(input logic [127:0] d);
        int k;
        k = 0;
        spread = '0;
        for (int p = 1; p <= 136; p++) begin
            if ((p & (p - 1)) != 0) begin
                spread[p] = d[k];
                k++;
            end
        end
    endfunction

    function automatic logic [127:0] gather(input logic [136:1] cw);
        int k;
        k = 0;
        gather = '0;
        for (int p = 1; p <= 136; p++) begin
            if ((p & (p - 1)) != 0) begin
                gather[k] = cw[p];
                k++;
            end
        end
    endfunction

    function automatic logic [7:0] syndrome(input logic [136:1] cw);
        syndrome = '0;
        for (int p = 1; p <= 136; p++) begin
            for (int i = 0; i < `NVM_CHECK_BITS; i++) begin
                if (((p >> i) & 1) != 0) begin
                    syndrome[i] = syndrome[i] ^ cw[p];
                end
            end
        end
    endfunction

    function automatic logic [WORD-1:0] encode(input logic [127:0] d);
        logic [7:0] c;
        c = syndrome(spread(d));
        encode = {(^d) ^ (^c), c, d};
    endfunction

    // Returns the status code above the corrected data.
    function automatic logic [129:0] decode(input logic [WORD-1:0] w);
        logic [136:1] cw;
        logic [7:0]   s;
        logic         ov;
        logic [1:0]   st;
        cw = spread(w[127:0]);
        s  = syndrome(cw) ^ w[135:128];
        ov = ^w;
        st = `NVM_ST_OK;
        if (ov) begin
            st = `NVM_ST_CORRECTED;
            if (s > 8'd136) begin
                st = `NVM_ST_DOUBLE;
            end else if (s != 8'h00) begin
                cw[s] = ~cw[s];
            end
        end else if (s != 8'h00) begin
            st = `NVM_ST_DOUBLE;
        end
        decode = {st, gather(cw)};
    endfunction

    // ************************************************************
    // Address decode
    // ************************************************************
    function automatic logic [`NVM_ADDR_BITS-1:0] word_addr(
        input logic [5:0] sec,
        input logic [5:0] page,
        input logic [3:0] blk);
        logic [`NVM_ADDR_BITS-1:0] pg;
        pg = `NVM_ADDR_BITS'(sec) * `NVM_ADDR_BITS'(`NVM_PAGES)
           + `NVM_ADDR_BITS'(page);
        word_addr = pg * `NVM_ADDR_BITS'(`NVM_BLOCKS)
                  + `NVM_ADDR_BITS'(blk);
    endfunction

    state_s cur;
    state_s next_cur;

    logic [5:0]                 req_sec;
    logic [5:0]                 req_page;
    logic [3:0]                 req_blk;
    logic [5:0]                 nxt_sec;
    logic [5:0]                 nxt_page;
    logic [3:0]                 nxt_blk;
    logic                       mem_we;
    logic [`NVM_ADDR_BITS-1:0]  mem_addr;
    logic [WORD-1:0]            mem_wdata;
    logic [WORD-1:0]            mem_rdata;
    logic [129:0]               dec;
    logic                       locked;
    logic                       page_match;

    // ************************************************************
    // Request address
    // ************************************************************
    always_comb begin
        req_sec  = addr_sector;
        req_page = reserved_page_select ? `NVM_SPARE_PAGE
                                        : {1'b0, addr_page};
        req_blk  = aux_block_select ? `NVM_AUX_BLOCK
                                    : {1'b0, addr_block};
        // Sequential reads walk the data blocks, then pages, then sectors.
        nxt_sec  = cur.sec;
        nxt_page = cur.page;
        nxt_blk  = cur.blk + 4'h1;
        if (cur.blk[2:0] == `NVM_LAST_DATA_BLK) begin
            nxt_blk  = 4'h0;
            nxt_page = cur.page + 6'h01;
            if (cur.page[4:0] == `NVM_LAST_USR_PAGE) begin
                nxt_page = 6'h00;
                nxt_sec  = cur.sec + 6'h01;
            end
        end
        if (sequential_read_request) begin
            req_sec  = nxt_sec;
            req_page = nxt_page;
            req_blk  = nxt_blk;
        end
        locked     = cur.protect[req_sec] && !page_write_unlock;
        page_match = (req_sec == cur.psec) && (req_page == cur.ppage);
    end

    // ************************************************************
    // Array port
    // ************************************************************
    always_comb begin
        mem_we    = 1'b0;
        mem_addr  = word_addr(req_sec, req_page, req_blk);
        mem_wdata = '0;
        if (cur.st == st_read) begin
            mem_addr = word_addr(cur.sec, cur.page, cur.blk);
        end else if (cur.st != st_idle) begin
            mem_addr = word_addr(cur.sec, cur.page, cur.cnt);
            mem_we   = (cur.st == st_erase) || cur.pvalid[cur.cnt];
            if (cur.st == st_program) begin
                mem_wdata = encode(cur.pbuf[cur.cnt]);
            end
        end
    end

    flash_nvm_array #(
        .WIDTH (WORD),
        .DEPTH (`NVM_WORDS),
        .ABITS (`NVM_ADDR_BITS)
    ) u_array (
        .core_clk (core_clk),
        .we       (mem_we),
        .addr     (mem_addr),
        .wdata    (mem_wdata),
        .rdata    (mem_rdata)
    );

    assign dec = decode(mem_rdata);

    // ************************************************************
    // Controller
    // ************************************************************
    always_comb begin
        next_cur        = cur;
        next_cur.rvalid = 1'b0;
        next_cur.done   = 1'b0;
        unique case (cur.st)
            st_idle: begin
                if (program_en || erase_page) begin
                    next_cur.sec      = req_sec;
                    next_cur.page     = req_page;
                    next_cur.cnt      = 4'h0;
                    next_cur.set_prot = protection_rewrite;
                    next_cur.clr_prot = page_write_unlock;
                    if (locked || (program_en && !erase_page
                                   && !page_match)) begin
                        next_cur.status = `NVM_ST_REFUSED;
                        next_cur.done   = 1'b1;
                    end else begin
                        next_cur.st = erase_page ? st_erase
                                                 : st_program;
                    end
                end else if (read_en || sequential_read_request) begin
                    next_cur.st   = st_read;
                    next_cur.sec  = req_sec;
                    next_cur.page = req_page;
                    next_cur.blk  = req_blk;
                    next_cur.cnt  = 4'h1;
                    next_cur.lat6 = six_cycle_read;
                end else if (write_en) begin
                    // A write to another page starts a fresh buffer.
                    if (!page_match) begin
                        next_cur.pvalid = '0;
                        next_cur.psec   = req_sec;
                        next_cur.ppage  = req_page;
                    end
                    next_cur.pbuf[req_blk]   = write_data;
                    next_cur.pvalid[req_blk] = 1'b1;
                end else if (page_buffer_drop) begin
                    next_cur.pvalid = '0;
                    next_cur.status = `NVM_ST_OK;
                    next_cur.done   = 1'b1;
                end
            end
            st_read: begin
                next_cur.cnt = cur.cnt + 4'h1;
                if (cur.cnt == (cur.lat6 ? `NVM_RD_LAT_SIX
                                         : `NVM_RD_LAT_FIVE)) begin
                    next_cur.st     = st_idle;
                    next_cur.rvalid = 1'b1;
                    // Unprogrammed buffer contents win over the array.
                    if (cur.pvalid[cur.blk] && cur.sec == cur.psec
                        && cur.page == cur.ppage) begin
                        next_cur.rdata  = cur.pbuf[cur.blk];
                        next_cur.status = `NVM_ST_OK;
                    end else begin
                        next_cur.rdata  = dec[127:0];
                        next_cur.status = dec[129:128];
                    end
                end
            end
            st_program,
            st_erase: begin
                next_cur.cnt = cur.cnt + 4'h1;
                if (cur.cnt == `NVM_LAST_BLOCK) begin
                    next_cur.st     = st_idle;
                    next_cur.done   = 1'b1;
                    next_cur.status = `NVM_ST_OK;
                    if (cur.st == st_program || (cur.sec == cur.psec
                        && cur.page == cur.ppage)) begin
                        next_cur.pvalid = '0;
                    end
                    if (cur.clr_prot) begin
                        next_cur.protect[cur.sec] = 1'b0;
                    end
                    if (cur.set_prot) begin
                        next_cur.protect[cur.sec] = 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign busy       = (cur.st != st_idle);
    assign read_data  = cur.rdata;
    assign status     = cur.status;
    assign read_valid = cur.rvalid;
    assign op_done    = cur.done;

endmodule

`default_nettype wire

// >>> flash_nvm_ctrl_monitor.sv
/* Port assertions for the flash storage controller.
   Assumes it is bound to flash_nvm_ctrl and sees one clock domain. */
`timescale 1ns/100ps
`default_nettype none
`include "flash_nvm_defs.svh"
module flash_nvm_monitor (
    // Clock and reset
    input wire logic         core_clk,
    input wire logic         arst_n,
    // Address
    input wire logic [5:0]   addr_sector,
    input wire logic [4:0]   addr_page,
    input wire logic [2:0]   addr_block,
    input wire logic         aux_block_select,
    input wire logic         reserved_page_select,
    // Requests
    input wire logic         read_en,
    input wire logic         sequential_read_request,
    input wire logic         six_cycle_read,
    input wire logic         write_en,
    input wire logic [127:0] write_data,
    input wire logic         program_en,
    input wire logic         erase_page,
    input wire logic         page_buffer_drop,
    input wire logic         page_write_unlock,
    input wire logic         protection_rewrite,
    // Answers
    input wire logic         busy,
    input wire logic [127:0] read_data,
    input wire logic [1:0]   status,
    input wire logic         read_valid,
    input wire logic         op_done
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    wire logic rd_req;
    wire logic pe_req;
    wire logic drop_req;
    assign pe_req = !busy && (program_en || erase_page);
    assign rd_req = !busy && !pe_req
                    && (read_en || sequential_read_request);
    assign drop_req = !busy && page_buffer_drop && !pe_req && !rd_req
                      && !write_en;
    a_read_five_cyc: assert property (
        rd_req && !six_cycle_read |=> busy[*5] ##1 (read_valid && !busy))
        else $error("five cycle read answer misplaced");
    a_read_six_cyc: assert property (
        rd_req && six_cycle_read |=> busy[*6] ##1 (read_valid && !busy))
        else $error("six cycle read answer misplaced");
    a_prog_erase_len: assert property (
        pe_req |=> (busy[*8] ##1 busy ##1 (op_done && !busy))
        or (op_done && !busy && status == `NVM_ST_REFUSED))
        else $error("program or erase answer misplaced");
    a_drop_answer: assert property (
        drop_req |=> !busy && op_done && status == `NVM_ST_OK)
        else $error("buffer drop answer misplaced");
    a_valid_pulse: assert property (read_valid |=> !read_valid)
        else $error("read valid longer than one cycle");
    a_done_pulse: assert property (op_done |=> !op_done)
        else $error("done longer than one cycle");
    a_data_holds: assert property (
        $changed(read_data) |-> read_valid)
        else $error("read data moved without a read answer");
    a_status_holds: assert property (
        $changed(status) |-> read_valid || op_done)
        else $error("status moved without an answer");
    a_idle_stays: assert property (
        !busy && !rd_req && !pe_req |=> !busy)
        else $error("busy rose without a request");
    a_busy_ends: assert property (
        $fell(busy) |-> read_valid || op_done)
        else $error("busy fell without an answer");
    c_read_six: cover property (rd_req && six_cycle_read);
    c_refused: cover property (op_done && status == `NVM_ST_REFUSED);
    c_seq_read: cover property (rd_req && sequential_read_request);
endmodule
bind flash_nvm_ctrl flash_nvm_monitor u_mon (.*);
`default_nettype wire

// >>> fabric_host_model.sv
/* Model of the fabric user logic that issues flash requests.
   Assumes requests are issued only while the controller is idle. */
`timescale 1ns/100ps
`default_nettype none
module fabric_host_model (
    // Clock
    input  wire logic         core_clk,
    // Requests and address
    output logic [5:0]        addr_sector,
    output logic [4:0]        addr_page,
    output logic [2:0]        addr_block,
    output logic              aux_block_select,
    output logic              reserved_page_select,
    output logic              read_en,
    output logic              sequential_read_request,
    output logic              six_cycle_read,
    output logic              write_en,
    output logic [127:0]      write_data,
    output logic              program_en,
    output logic              erase_page,
    output logic              page_buffer_drop,
    output logic              page_write_unlock,
    output logic              protection_rewrite
);
    logic [7:0] ops_q;
    // Controls are active high and sampled on the rising edge.
    assign {protection_rewrite, page_write_unlock, page_buffer_drop,
            erase_page, program_en, write_en, sequential_read_request,
            read_en} = ops_q;
    initial begin
        ops_q = 8'h00;
        {addr_sector, addr_page, addr_block} = 14'h0000;
        {aux_block_select, reserved_page_select, six_cycle_read} = 3'h0;
        write_data = 128'h0;
    end
    // Held from one falling edge to the next around the taking edge.
    task automatic send(input logic [7:0] ops, input logic [5:0] sec,
        input logic [4:0] pg, input logic [3:0] blk, input logic sp,
        input logic six, input logic [127:0] data);
        @(negedge core_clk);
        ops_q = ops;
        addr_sector = sec;
        addr_page = pg;
        addr_block = blk[2:0];
        aux_block_select = blk[3];
        reserved_page_select = sp;
        six_cycle_read = six;
        write_data = data;
        @(negedge core_clk);
        ops_q = 8'h00;
        // Stale data is inverted so nothing leans on it being held.
        write_data = ~write_data;
    endtask
endmodule
`default_nettype wire

// >>> tb.sv
/* Self-checking testbench of the flash storage controller.
   Assumes the host model drives requests and the monitor is bound. */
`timescale 1ns/100ps
`default_nettype none
`include "flash_nvm_defs.svh"
module tb;
    logic              core_clk;
    logic              arst_n;
    wire logic [5:0]   addr_sector;
    wire logic [4:0]   addr_page;
    wire logic [2:0]   addr_block;
    wire logic         aux_block_select, reserved_page_select, read_en,
        sequential_read_request, six_cycle_read, write_en, program_en,
        erase_page, page_buffer_drop, page_write_unlock,
        protection_rewrite, busy, read_valid, op_done;
    wire logic [127:0] write_data, read_data;
    wire logic [1:0]   status;
    int                num_errors;
    int                n_tests;
    fabric_host_model u_host (.*);
    flash_nvm_ctrl u_dut (.*);
    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic cmp(input logic [127:0] got, input logic [127:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask
    function automatic logic [127:0] pat(input int s, p, b);
        return {32'(s), 32'(p), 32'(b), 32'hC3A50F1E};
    endfunction
    task automatic wait_ans(input int lat);
        int cnt;
        cnt = 0;
        while (cnt < 20 && read_valid !== 1'b1 && op_done !== 1'b1) begin
            @(posedge core_clk);
            #1;
            cnt++;
        end
        if (cnt == 20) begin
            num_errors++;
            print_verdict();
        end
        cmp(128'(cnt), 128'(lat));
    endtask
    task automatic op(input logic [7:0] ops, input logic [5:0] s,
        input logic [4:0] p, input logic sp, input int lat,
        input logic [1:0] es);
        u_host.send(ops, s, p, 4'h0, sp, 1'b0, 128'h0);
        wait_ans(lat);
        cmp(128'(status), 128'(es));
    endtask
    task automatic rd(input logic [7:0] ops, input logic [5:0] s,
        input logic [4:0] p, input logic [3:0] b, input logic sp,
        input logic six, input logic [127:0] ed);
        u_host.send(ops, s, p, b, sp, six, 128'h0);
        wait_ans(six ? 6 : 5);
        cmp(read_data, ed);
        cmp(128'(status), 128'(`NVM_ST_OK));
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        cmp(128'({busy, read_valid, op_done, status}), 128'h0);
        cmp(read_data, 128'h0);
    endtask
    task automatic t_page();
        for (int b = 0; b < 9; b++)
            u_host.send(8'h04, 6'h03, 5'h05, 4'(b), 1'b0, 1'b0,
                        pat(3, 5, b));
        op(8'h08, 6'h03, 5'h05, 1'b0, 9, `NVM_ST_OK);
        for (int b = 0; b < 9; b++)
            rd(8'h01, 6'h03, 5'h05, 4'(b), 1'b0, 1'(b), pat(3, 5, b));
        rd(8'h01, 6'h03, 5'h05, 4'h2, 1'b0, 1'b0, pat(3, 5, 2));
        rd(8'h02, 6'h00, 5'h00, 4'h0, 1'b0, 1'b1, pat(3, 5, 3));
    endtask
    task automatic t_spare();
        u_host.send(8'h04, 6'h03, 5'h00, 4'h1, 1'b1, 1'b0,
                    pat(3, 32, 1));
        op(8'h08, 6'h03, 5'h00, 1'b1, 9, `NVM_ST_OK);
        rd(8'h01, 6'h03, 5'h00, 4'h1, 1'b1, 1'b0, pat(3, 32, 1));
    endtask
    task automatic t_buffer();
        u_host.send(8'h04, 6'h01, 5'h09, 4'h4, 1'b0, 1'b0,
                    pat(1, 9, 4));
        rd(8'h01, 6'h01, 5'h09, 4'h4, 1'b0, 1'b0, pat(1, 9, 4));
        op(8'h20, 6'h01, 5'h09, 1'b0, 0, `NVM_ST_OK);
    endtask
    task automatic t_protect();
        op(8'h90, 6'h03, 5'h05, 1'b0, 9, `NVM_ST_OK);
        rd(8'h01, 6'h03, 5'h05, 4'h0, 1'b0, 1'b0, 128'h0);
        op(8'h10, 6'h03, 5'h05, 1'b0, 0, `NVM_ST_REFUSED);
        op(8'h50, 6'h03, 5'h05, 1'b0, 9, `NVM_ST_OK);
    endtask
    // ****************************************************************
    // Run
    // ****************************************************************
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    initial begin
        num_errors = 0;
        n_tests = 0;
        arst_n = 1'b0;
        repeat (5) @(posedge core_clk);
        @(negedge core_clk);
        arst_n = 1'b1;
        t_reset();
        t_page();
        t_spare();
        t_buffer();
        t_protect();
        print_verdict();
    end
endmodule
`default_nettype wire
